// ==== shared/usf_defines.svh ====
// register offsets, field positions, reset values of the status-flag block
`ifndef USF_DEFINES_SVH
`define USF_DEFINES_SVH

`define USF_ADDR_W          3
`define USF_OFS_STATUS      3'h0
`define USF_OFS_MODE        3'h1
`define USF_OFS_CMD         3'h2
`define USF_OFS_SYNC_ONE    3'h3
`define USF_OFS_SYNC_TWO    3'h4
`define USF_OFS_DLE         3'h5
`define USF_OFS_DATA        3'h6

`define USF_MODE_SYNC       0
`define USF_MODE_STOP_LO    2
`define USF_MODE_STOP_HI    3
`define USF_MODE_PARITY     4
`define USF_MODE_TRANSP     6
`define USF_MODE_SINGLE     7

`define USF_CMD_TX_ON       0
`define USF_CMD_RX_ON       2
`define USF_CMD_ERR_RESET   4
`define USF_CMD_SUB_LO      6
`define USF_CMD_SUB_HI      7

`define USF_ST_TX_FREE      0
`define USF_ST_RX_FULL      1
`define USF_ST_EMPTY_CHG    2
`define USF_ST_PARITY_DLE   3
`define USF_ST_OVERRUN      4
`define USF_ST_FRAME_SYN    5
`define USF_ST_DCD          6
`define USF_ST_DSR          7

`define USF_RST_BYTE        8'h00
`define USF_RST_MODEM_PINS  2'h3
`define USF_CMD_KEEP_MASK   8'hEF

`endif

// ==== shared/usf_pkg.sv ====
// types of the status-flag block
package usf_pkg;

   typedef enum logic [1:0] {
      USF_SUB_NORMAL = 2'h0,
      USF_SUB_ECHO   = 2'h1,
      USF_SUB_LOCAL  = 2'h2,
      USF_SUB_REMOTE = 2'h3
   } usf_submode_t;

   typedef enum logic [1:0] {
      USF_STOP_NONE = 2'h0,
      USF_STOP_ONE  = 2'h1,
      USF_STOP_HALF = 2'h2,
      USF_STOP_TWO  = 2'h3
   } usf_stop_t;

endpackage

// ==== verilog/usf_status.sv ====
// status flags, mode/command registers and flag pins of the serial controller
//
// Operation
// - tx holding free is 1, loaded is 0
// - tx free set on enable, never echo/remote
// - tx free pin low when set, high echo/remote
// - rx full set on load, cleared on read
// - rx full pin low while flag set
// - tx empty after sent character, cleared on write
// - modem change sets shared flag, cleared by read
// - empty/change pin low while flag set; high in remote, modem change only in echo
// - parity error or first DLE sets flag
// - rx disable and error reset clear errors
// - overrun when unread character is replaced
// - framing checks first stop bit at 1.5
// - break means framing set and zero character
// - non-transparent sync sets sync detect flag
// - transparent sync and DLE-SYN sets flag
// - framing/sync clear by disable, reset, read
// - status bits 6,7 mirror DCD and DSR
// - low modem input reads as set bit
// - error reset is one-shot, never stored
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "usf_defines.svh"
`default_nettype none

module usf_status
   import usf_pkg::*;
(
   input  wire logic                   clock,
   input  wire logic                   rst_n,
   input  wire logic [`USF_ADDR_W-1:0] addr,
   input  wire logic [7:0]             wdata,
   input  wire logic                   wr,
   input  wire logic                   rd,
   output logic      [7:0]             rdata,
   input  wire logic                   tx_load_taken,
   input  wire logic                   tx_char_done,
   input  wire logic                   rx_load,
   input  wire logic [7:0]             rx_char,
   input  wire logic                   rx_parity_bad,
   input  wire logic                   rx_stop1_bad,
   input  wire logic                   rx_stop2_bad,
   input  wire logic                   dcd_n,
   input  wire logic                   dsr_n,
   output logic                        transmitter_on,
   output logic                        receiver_on,
   output logic      [7:0]             tx_holding_reg,
   output logic                        tx_holding_free_n,
   output logic                        rx_holding_full_n,
   output logic                        tx_idle_or_modem_change_n,
   output logic                        line_break
);

   function automatic logic char_is(input logic [7:0] c, input logic [7:0] ref_c);
      char_is = (c == ref_c);
   endfunction

   // ---------------- registers
   logic [7:0] mode_q;
   logic [7:0] cmd_q;
   logic [7:0] sync_char_one_q;
   logic [7:0] sync_char_two_q;
   logic [7:0] dle_char_q;
   logic [7:0] tx_hold_q;
   logic [7:0] rx_holding_reg_q;
   logic [7:0] rdata_q;

   logic       hold_loaded_q,  hold_loaded_d;
   logic       sent_one_q,     sent_one_d;
   logic       tx_free_q,      tx_free_d;
   logic       tx_empty_q,     tx_empty_d;
   logic       modem_chg_q,    modem_chg_d;
   logic       rx_full_q,      rx_full_d;
   logic       parity_dle_q,   parity_dle_d;
   logic       overrun_q,      overrun_d;
   logic       frame_syn_q,    frame_syn_d;
   logic       dle_first_q,    dle_first_d;
   logic       sync_char_one_prev_q,    sync_char_one_prev_d;
   logic       synced_q,       synced_d;
   logic       line_break_q;
   logic       tx_pin_q,       rx_pin_q,    empty_pin_q;

   logic [1:0] modem_s1_q;
   logic [1:0] modem_s2_q;
   logic [1:0] modem_s3_q;
   logic [1:0] modem_flt_q;

   // ---------------- bus decode
   wire        wr_mode        = wr & (addr == `USF_OFS_MODE);
   wire        wr_cmd         = wr & (addr == `USF_OFS_CMD);
   wire        wr_sync_char_one        = wr & (addr == `USF_OFS_SYNC_ONE);
   wire        wr_sync_char_two        = wr & (addr == `USF_OFS_SYNC_TWO);
   wire        wr_dle         = wr & (addr == `USF_OFS_DLE);
   wire        wr_data        = wr & (addr == `USF_OFS_DATA);
   wire        rd_status      = rd & (addr == `USF_OFS_STATUS);
   wire        rd_data        = rd & (addr == `USF_OFS_DATA);

   // one-shot: acts in the write cycle only, bit never kept
   wire        err_reset      = wr_cmd & wdata[`USF_CMD_ERR_RESET];

   // ---------------- mode and command fields
   wire        sync_mode      = mode_q[`USF_MODE_SYNC];
   wire        parity_on      = mode_q[`USF_MODE_PARITY];
   wire        transparent    = mode_q[`USF_MODE_TRANSP];
   wire        single_sync    = mode_q[`USF_MODE_SINGLE];
   wire        stop_half      = usf_stop_t'(mode_q[`USF_MODE_STOP_HI:`USF_MODE_STOP_LO])
                                == USF_STOP_HALF;
   wire        stop_two       = usf_stop_t'(mode_q[`USF_MODE_STOP_HI:`USF_MODE_STOP_LO])
                                == USF_STOP_TWO;
   wire        tx_on          = cmd_q[`USF_CMD_TX_ON];
   wire        rx_on          = cmd_q[`USF_CMD_RX_ON];
   wire usf_submode_t submode = usf_submode_t'(cmd_q[`USF_CMD_SUB_HI:`USF_CMD_SUB_LO]);
   // echo only exists in async; the same code means stripping in sync
   wire        echo_mode      = (submode == USF_SUB_ECHO) & ~sync_mode;
   wire        remote_mode    = (submode == USF_SUB_REMOTE);
   wire        looped_tx      = echo_mode | remote_mode;

   // ---------------- modem inputs: three stages, accept when last two agree
   wire [1:0]  modem_stable   = ~(modem_s2_q ^ modem_s3_q);
   wire [1:0]  modem_flt_d    = (modem_stable & modem_s3_q) | (~modem_stable & modem_flt_q);
   wire        modem_event    = |(modem_flt_d ^ modem_flt_q);

   // ---------------- transmitter flags
   always_comb begin
      hold_loaded_d = hold_loaded_q;
      if (tx_load_taken)
         hold_loaded_d = 1'b0;
      if (wr_data & ~looped_tx)
         hold_loaded_d = 1'b1;
   end

   // idle report waits for a real character to have gone out
   assign sent_one_d    = tx_on & (sent_one_q | tx_load_taken);

   // free while enabled and empty; enabling with a loaded char leaves it 0
   assign tx_free_d     = tx_on & ~hold_loaded_d & ~looped_tx;

   // fill characters count as a finished character too; set wins over the write
   wire   tx_empty_set  = tx_char_done & sent_one_q & ~hold_loaded_q;
   assign tx_empty_d    = tx_on & (tx_empty_set | (tx_empty_q & ~wr_data));

   // change only counts while either direction is enabled
   wire   modem_set     = modem_event & (tx_on | rx_on);
   assign modem_chg_d   = modem_set | (modem_chg_q & ~rd_status);

   // ---------------- receiver flags
   wire   rx_evt        = rx_load & rx_on;
   wire   rx_take       = rx_evt & ~remote_mode;
   wire   is_sync_char_one       = char_is(rx_char, sync_char_one_q);
   wire   is_sync_char_two       = char_is(rx_char, sync_char_two_q);
   wire   is_dle        = char_is(rx_char, dle_char_q);

   // a read in the same cycle as a new load still leaves the flag set
   assign rx_full_d     = rx_on & ~remote_mode & (rx_take | (rx_full_q & ~rd_data));

   // remote loop never fills the holding reg, so no overrun can arise there
   wire   overrun_set   = rx_evt & rx_full_q & ~rd_data;
   assign overrun_d     = rx_on & (overrun_set | (overrun_q & ~err_reset));

   wire   parity_set    = rx_evt & parity_on & rx_parity_bad;
   wire   dle_set       = rx_evt & sync_mode & transparent & ~parity_on
                          & is_dle & ~dle_first_q;
   assign parity_dle_d  = rx_on & (parity_set | dle_set | (parity_dle_q & ~err_reset));

   // a DLE that followed a counted DLE starts no new pair
   assign dle_first_d   = rx_on & (rx_evt ? (is_dle & ~dle_first_q) : dle_first_q);
   assign sync_char_one_prev_d   = rx_on & (rx_evt ? is_sync_char_one : sync_char_one_prev_q);

   wire   init_hit      = single_sync ? is_sync_char_one : (sync_char_one_prev_q & is_sync_char_two);
   wire   plain_syn     = ~transparent & init_hit;
   wire   first_syn     = transparent & ~synced_q & init_hit;
   wire   dle_syn       = transparent & synced_q & dle_first_q & is_sync_char_one;
   wire   syn_set       = rx_evt & sync_mode & (plain_syn | first_syn | dle_syn);
   assign synced_d      = rx_on & sync_mode & (synced_q | (rx_evt & first_syn));

   // at 1.5 stop bits the half bit is never checked
   wire   second_stop   = stop_two & ~stop_half;
   wire   frame_set     = rx_evt & ~sync_mode
                          & (rx_stop1_bad | (second_stop & rx_stop2_bad));
   wire   frame_clr     = (err_reset & ~sync_mode) | (rd_status & sync_mode);
   assign frame_syn_d   = rx_on & (frame_set | syn_set | (frame_syn_q & ~frame_clr));

   // ---------------- status byte
   wire [7:0] status_byte;
   assign status_byte[`USF_ST_TX_FREE]    = tx_free_q;
   assign status_byte[`USF_ST_RX_FULL]    = rx_full_q;
   assign status_byte[`USF_ST_EMPTY_CHG]  = tx_empty_q | modem_chg_q;
   assign status_byte[`USF_ST_PARITY_DLE] = parity_dle_q;
   assign status_byte[`USF_ST_OVERRUN]    = overrun_q;
   assign status_byte[`USF_ST_FRAME_SYN]  = frame_syn_q;
   assign status_byte[`USF_ST_DCD]        = ~modem_flt_q[0];
   assign status_byte[`USF_ST_DSR]        = ~modem_flt_q[1];

   // ---------------- pins, from next-state so pin and bit agree in time
   wire   tx_pin_d      = ~tx_free_d;
   wire   rx_pin_d      = ~rx_full_d;
   wire   empty_flag_d  = echo_mode ? modem_chg_d : (tx_empty_d | modem_chg_d);
   wire   empty_pin_d   = remote_mode | ~empty_flag_d;
   wire   break_d       = frame_syn_d & ~sync_mode
                          & ((rx_take ? rx_char : rx_holding_reg_q) == `USF_RST_BYTE);

   // ---------------- read mux; status write address is simply not decoded
   wire [7:0] rd_mux =
      (addr == `USF_OFS_STATUS)   ? status_byte :
      (addr == `USF_OFS_MODE)     ? mode_q :
      (addr == `USF_OFS_CMD)      ? cmd_q :
      (addr == `USF_OFS_SYNC_ONE) ? sync_char_one_q :
      (addr == `USF_OFS_SYNC_TWO) ? sync_char_two_q :
      (addr == `USF_OFS_DLE)      ? dle_char_q :
      (addr == `USF_OFS_DATA)     ? rx_holding_reg_q :
                                    `USF_RST_BYTE;

   // ---------------- software registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mode_q          <= `USF_RST_BYTE;
         cmd_q           <= `USF_RST_BYTE;
         sync_char_one_q <= `USF_RST_BYTE;
         sync_char_two_q <= `USF_RST_BYTE;
         dle_char_q      <= `USF_RST_BYTE;
      end else begin
         if (wr_mode)
            mode_q <= wdata;
         if (wr_cmd)
            cmd_q <= wdata & `USF_CMD_KEEP_MASK;
         if (wr_sync_char_one)
            sync_char_one_q <= wdata;
         if (wr_sync_char_two)
            sync_char_two_q <= wdata;
         if (wr_dle)
            dle_char_q <= wdata;
      end
   end

   // ---------------- data holding and read data
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tx_hold_q        <= `USF_RST_BYTE;
         rx_holding_reg_q <= `USF_RST_BYTE;
         rdata_q          <= `USF_RST_BYTE;
      end else begin
         if (wr_data & ~looped_tx)
            tx_hold_q <= wdata;
         if (rx_take)
            rx_holding_reg_q <= rx_char;
         rdata_q <= rd ? rd_mux : `USF_RST_BYTE;
      end
   end

   // ---------------- modem synchroniser
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         modem_s1_q  <= `USF_RST_MODEM_PINS;
         modem_s2_q  <= `USF_RST_MODEM_PINS;
         modem_s3_q  <= `USF_RST_MODEM_PINS;
         modem_flt_q <= `USF_RST_MODEM_PINS;
      end else begin
         modem_s1_q  <= {dsr_n, dcd_n};
         modem_s2_q  <= modem_s1_q;
         modem_s3_q  <= modem_s2_q;
         modem_flt_q <= modem_flt_d;
      end
   end

   // ---------------- flags
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         hold_loaded_q <= 1'b0;
         sent_one_q    <= 1'b0;
         tx_free_q     <= 1'b0;
         tx_empty_q    <= 1'b0;
         modem_chg_q   <= 1'b0;
         rx_full_q     <= 1'b0;
         parity_dle_q  <= 1'b0;
         overrun_q     <= 1'b0;
         frame_syn_q   <= 1'b0;
         dle_first_q   <= 1'b0;
         sync_char_one_prev_q   <= 1'b0;
         synced_q      <= 1'b0;
      end else begin
         hold_loaded_q <= hold_loaded_d;
         sent_one_q    <= sent_one_d;
         tx_free_q     <= tx_free_d;
         tx_empty_q    <= tx_empty_d;
         modem_chg_q   <= modem_chg_d;
         rx_full_q     <= rx_full_d;
         parity_dle_q  <= parity_dle_d;
         overrun_q     <= overrun_d;
         frame_syn_q   <= frame_syn_d;
         dle_first_q   <= dle_first_d;
         sync_char_one_prev_q   <= sync_char_one_prev_d;
         synced_q      <= synced_d;
      end
   end

   // ---------------- pins
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tx_pin_q     <= 1'b1;
         rx_pin_q     <= 1'b1;
         empty_pin_q  <= 1'b1;
         line_break_q <= 1'b0;
      end else begin
         tx_pin_q     <= tx_pin_d;
         rx_pin_q     <= rx_pin_d;
         empty_pin_q  <= empty_pin_d;
         line_break_q <= break_d;
      end
   end

   assign rdata                     = rdata_q;
   assign transmitter_on            = tx_on;
   assign receiver_on               = rx_on;
   assign tx_holding_reg            = tx_hold_q;
   assign tx_holding_free_n         = tx_pin_q;
   assign rx_holding_full_n         = rx_pin_q;
   assign tx_idle_or_modem_change_n = empty_pin_q;
   assign line_break                = line_break_q;

endmodule

`default_nettype wire

// ==== sim/usf_status_monitor.sv ====
// concurrent checks on the status-flag block ports
`timescale 1ns/1ps
`include "usf_defines.svh"
`default_nettype none
module usf_monitor (
   input wire logic                   clock,
   input wire logic                   rst_n,
   input wire logic [`USF_ADDR_W-1:0] addr,
   input wire logic [7:0]             wdata,
   input wire logic                   wr,
   input wire logic                   rd,
   input wire logic [7:0]             rdata,
   input wire logic                   tx_load_taken,
   input wire logic                   rx_load,
   input wire logic                   dcd_n,
   input wire logic                   dsr_n,
   input wire logic                   receiver_on,
   input wire logic                   tx_holding_free_n,
   input wire logic                   rx_holding_full_n,
   input wire logic                   tx_idle_or_modem_change_n,
   input wire logic                   line_break
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // long enough to cover the modem synchroniser after a reset
   sequence modem_quiet;
      ($stable(dcd_n) && $stable(dsr_n)) [*8];
   endsequence
   sequence err_cmd;
      wr && addr == `USF_OFS_CMD && wdata[`USF_CMD_ERR_RESET] && !rx_load ##1 !rx_load;
   endsequence
   idle_read_a: assert property (!rd |=> rdata == 8'h00)
      else $error("read data not zero outside a read");
   unmapped_a: assert property (rd && addr == 3'h7 |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   cmd_oneshot_a: assert property (rd && addr == `USF_OFS_CMD |=> !rdata[4])
      else $error("error reset bit stored");
   load_busy_a: assert property (wr && addr == `USF_OFS_DATA && !tx_load_taken
      |=> tx_holding_free_n) else $error("holding free pin low after load");
   rx_drain_a: assert property (rd && addr == `USF_OFS_DATA && !rx_load
      |=> rx_holding_full_n) else $error("rx full pin low after data read");
   remote_quiet_a: assert property (wr && addr == `USF_OFS_CMD && wdata[7:6] == 2'h3
      |=> ##1 tx_holding_free_n && rx_holding_full_n && tx_idle_or_modem_change_n)
      else $error("pins not high in remote loop");
   rx_off_a: assert property (!receiver_on [*2] |-> rx_holding_full_n && !line_break)
      else $error("rx flags active with receiver off");
   err_clear_a: assert property (err_cmd |=> !line_break)
      else $error("break kept after error reset");
   modem_mirror_a: assert property (modem_quiet ##0 (rd && addr == `USF_OFS_STATUS)
      |=> rdata[6] == !$past(dcd_n) && rdata[7] == !$past(dsr_n))
      else $error("modem bits do not mirror inputs");
endmodule
bind usf_status usf_monitor u_mon (.clock(clock), .rst_n(rst_n), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .tx_load_taken(tx_load_taken),
   .rx_load(rx_load), .dcd_n(dcd_n), .dsr_n(dsr_n), .receiver_on(receiver_on),
   .tx_holding_free_n(tx_holding_free_n), .rx_holding_full_n(rx_holding_full_n),
   .tx_idle_or_modem_change_n(tx_idle_or_modem_change_n), .line_break(line_break));
`default_nettype wire

// ==== sim/usf_host_model.sv ====
// host processor model driving the register port
`timescale 1ns/1ps
`include "usf_defines.svh"
`default_nettype none
module usf_host_model (
   input  wire logic                   clock,
   input  wire logic [7:0]             rdata,
   output logic      [`USF_ADDR_W-1:0] addr,
   output logic      [7:0]             wdata,
   output logic                        wr,
   output logic                        rd
);
   initial begin
      addr = 3'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
   end
   task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      @(posedge clock);
      d = rdata;
   endtask
endmodule
`default_nettype wire

// ==== sim/usf_status_tb_top.sv ====
// self-checking bench of the status-flag block
`timescale 1ns/1ps
`include "usf_defines.svh"
`default_nettype none
module usf_status_tb_top;
   logic       clock, rst_n, wr, rd, dcd_n, dsr_n, tx_on, rx_on, brk;
   logic       tx_load_taken, tx_char_done, rx_load, rx_parity_bad, rx_stop1_bad;
   logic       rx_stop2_bad, free_n, full_n, empty_n;
   logic [2:0] addr;
   logic [7:0] wdata, rdata, rx_char, hold, s;
   int         fail_count, check_count;
   usf_host_model u_host (.clock(clock), .rdata(rdata), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd));
   usf_status u_dut (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .tx_load_taken(tx_load_taken), .tx_char_done(tx_char_done),
      .rx_load(rx_load), .rx_char(rx_char), .rx_parity_bad(rx_parity_bad),
      .rx_stop1_bad(rx_stop1_bad), .rx_stop2_bad(rx_stop2_bad), .dcd_n(dcd_n),
      .dsr_n(dsr_n), .transmitter_on(tx_on), .receiver_on(rx_on), .tx_holding_reg(hold),
      .tx_holding_free_n(free_n), .rx_holding_full_n(full_n),
      .tx_idle_or_modem_change_n(empty_n), .line_break(brk));
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic w(input logic [2:0] a, input logic [7:0] d);
      u_host.bus_wr(a, d);
      #1;
   endtask
   task automatic rs(input logic [7:0] m, input logic [7:0] exp);
      u_host.bus_rd(`USF_OFS_STATUS, s);
      chk("status", s & m, exp);
   endtask
   task automatic pins(input logic [2:0] exp);
      chk("pins", {5'h00, free_n, full_n, empty_n}, {5'h00, exp});
   endtask
   // bits: tx load taken, tx done, rx load, parity bad, stop1 bad, stop2 bad
   task automatic ev(input logic [5:0] p, input logic [7:0] c);
      @(posedge clock);
      {tx_load_taken, tx_char_done, rx_load, rx_parity_bad, rx_stop1_bad, rx_stop2_bad} <= p;
      rx_char <= c;
      @(posedge clock);
      {tx_load_taken, tx_char_done, rx_load, rx_parity_bad, rx_stop1_bad, rx_stop2_bad} <= 6'h00;
      #1;
   endtask
   task automatic t_tx;
      pins(3'b111);
      rs(8'hFF, 8'h00);
      w(`USF_OFS_CMD, 8'h01);
      // enable reaches the flag one edge after the command register
      @(posedge clock);
      #1;
      pins(3'b011);
      rs(8'h07, 8'h01);
      w(`USF_OFS_DATA, 8'hA5);
      pins(3'b111);
      ev(6'h20, 8'h00);
      pins(3'b011);
      ev(6'h10, 8'h00);
      pins(3'b010);
      rs(8'h07, 8'h05);
      w(`USF_OFS_DATA, 8'h3C);
      pins(3'b111);
      chk("holding", hold, 8'h3C);
      $display("test tx done");
   endtask
   task automatic t_rx;
      w(`USF_OFS_CMD, 8'h05);
      ev(6'h08, 8'h5A);
      pins(3'b101);
      ev(6'h08, 8'h3C);
      rs(8'h1F, 8'h12);
      u_host.bus_rd(`USF_OFS_DATA, s);
      chk("rx data", s, 8'h3C);
      pins(3'b111);
      w(`USF_OFS_CMD, 8'h15);
      rs(8'h1F, 8'h00);
      u_host.bus_rd(`USF_OFS_CMD, s);
      chk("command", s, 8'h05);
      w(`USF_OFS_MODE, 8'h10);
      ev(6'h0C, 8'h41);
      rs(8'h0A, 8'h0A);
      w(`USF_OFS_CMD, 8'h01);
      rs(8'h3E, 8'h00);
      $display("test rx done");
   endtask
   task automatic t_frame;
      w(`USF_OFS_CMD, 8'h05);
      w(`USF_OFS_MODE, 8'h08);
      ev(6'h09, 8'h00);
      rs(8'h20, 8'h00);
      u_host.bus_rd(`USF_OFS_DATA, s);
      ev(6'h0A, 8'h00);
      chk("break", {7'h00, brk}, 8'h01);
      rs(8'h20, 8'h20);
      rs(8'h20, 8'h20);
      w(`USF_OFS_CMD, 8'h15);
      rs(8'h38, 8'h00);
      w(`USF_OFS_MODE, 8'h0C);
      ev(6'h09, 8'h11);
      rs(8'h20, 8'h20);
      chk("break", {7'h00, brk}, 8'h00);
      w(`USF_OFS_CMD, 8'h15);
      $display("test framing done");
   endtask
   task automatic t_sync;
      w(`USF_OFS_SYNC_ONE, 8'h16);
      w(`USF_OFS_DLE, 8'h10);
      w(`USF_OFS_MODE, 8'h81);
      ev(6'h08, 8'h16);
      rs(8'h20, 8'h20);
      rs(8'h20, 8'h00);
      w(`USF_OFS_MODE, 8'hC1);
      ev(6'h08, 8'h16);
      rs(8'h20, 8'h20);
      ev(6'h08, 8'h10);
      rs(8'h08, 8'h08);
      w(`USF_OFS_CMD, 8'h15);
      ev(6'h08, 8'h10);
      rs(8'h28, 8'h00);
      ev(6'h08, 8'h41);
      ev(6'h08, 8'h10);
      ev(6'h08, 8'h16);
      rs(8'h20, 8'h20);
      // double sync: the first character alone must not count
      w(`USF_OFS_SYNC_TWO, 8'h2A);
      w(`USF_OFS_MODE, 8'h01);
      ev(6'h08, 8'h16);
      rs(8'h20, 8'h00);
      ev(6'h08, 8'h2A);
      rs(8'h20, 8'h20);
      $display("test sync done");
   endtask
   task automatic t_modem;
      w(`USF_OFS_MODE, 8'h00);
      rs(8'hC0, 8'h00);
      @(posedge clock);
      dcd_n <= 1'b0;
      dsr_n <= 1'b0;
      repeat (6) @(posedge clock);
      #1;
      chk("change pin", {7'h00, empty_n}, 8'h00);
      rs(8'hC4, 8'hC4);
      rs(8'hC4, 8'hC0);
      w(`USF_OFS_CMD, 8'h00);
      @(posedge clock);
      dcd_n <= 1'b1;
      repeat (6) @(posedge clock);
      rs(8'hC4, 8'h80);
      $display("test modem done");
   endtask
   task automatic t_remote;
      w(`USF_OFS_MODE, 8'h10);
      // async echo: holding emptied, yet the free flag and pin stay off
      w(`USF_OFS_CMD, 8'h45);
      ev(6'h20, 8'h00);
      pins(3'b111);
      w(`USF_OFS_DATA, 8'h77);
      chk("holding", hold, 8'h3C);
      rs(8'h01, 8'h00);
      w(`USF_OFS_CMD, 8'hC5);
      @(posedge clock);
      #1;
      pins(3'b111);
      ev(6'h0C, 8'h22);
      rs(8'h1B, 8'h08);
      w(`USF_OFS_STATUS, 8'hFF);
      rs(8'hFF, 8'h88);
      u_host.bus_rd(3'h7, s);
      chk("unmapped", s, 8'h00);
      $display("test remote done");
   endtask
   initial begin
      rst_n = 1'b0;
      dcd_n = 1'b1;
      dsr_n = 1'b1;
      rx_char = 8'h00;
      {tx_load_taken, tx_char_done, rx_load, rx_parity_bad, rx_stop1_bad, rx_stop2_bad} = 6'h00;
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      t_tx();
      t_rx();
      t_frame();
      t_sync();
      t_modem();
      t_remote();
      end_sim();
   end
   initial begin
      repeat (20000) @(posedge clock);
      fail_count++;
      end_sim();
   end
endmodule
`default_nettype wire
